// ===== common/mmdec_defs.svh
/*
 Address map constants for the memory map address decoder.
 Assumes a 20-bit byte address from the processor core and byte-addressed peripheral registers, eight or sixteen bits wide.
*/
// Notes on behaviour
// [R01] Every 20-bit address from 00000h to FFFFFh falls into exactly one target region or is reserved.
// [R02] Program ROM ends at 0FFFFh and extends downward by its size, so 16 Kbyte starts at 0C000h.
// [R03] The fixed vector table sits at 0FFDCh to 0FFFFh inside program ROM and holds routine starts.
// [R04] Addresses 02400h to 02BFFh select the data flash, apart from program ROM.
// [R05] Internal RAM starts at 00400h and grows upward, 1 Kbyte ending at 007FFh, for data and stack.
// [R06] Addresses 00000h to 002FFh select the special function area of peripheral controls.
// [R07] A special function location with no register is reserved and routed to no register.
// [R08] Bytes 00A0h to 00A6h select the serial unit mode, bit rate, transmit, two controls, receive.
// [R09] Converter registers sit at 00C0h-00C1h, 00D4h, 00D6h, 00D7h, 00D8h, 00DAh and 00DCh.
// [R10] Port, pin select, port mode, input enable, filter and pull-up registers sit in 00E0h-00FFh.
// [R11] Timer and bus protocol registers sit in 0100h to 0132h at their own byte addresses.
// [R12] Sixteen-bit registers take two consecutive bytes with the low byte at the even address.
// [R13] An address in no defined region asserts no select and reads back an undefined value; the code raises sel_reserved for it.
// [R14] Region selection follows the presented address combinationally within the same cycle; the code registers the selects, one cycle later.
`ifndef MMDEC_DEFS_SVH
`define MMDEC_DEFS_SVH

`define MMDEC_ADDR_W 20
`define MMDEC_SFA_LO 20'h00000
`define MMDEC_SFA_HI 20'h002ff
`define MMDEC_RAM_LO 20'h00400
`define MMDEC_RAM_SIZE 20'h00400
`define MMDEC_DFL_LO 20'h02400
`define MMDEC_DFL_HI 20'h02bff
`define MMDEC_ROM_TOP 20'h0ffff
`define MMDEC_ROM_SIZE 20'h04000
`define MMDEC_VEC_LO 20'h0ffdc
`define MMDEC_REG_SLOTS 256
`define MMDEC_REG_BASE 20'h000a0

`endif

// ===== common/mmdec_pkg.sv
/*
 Types for the memory map address decoder.
 Assumes the constants header is compiled alongside.
*/
package mmdec_pkg;
    typedef enum logic [2:0] {
        MMDEC_REGION_NONE = 3'h0,
        MMDEC_REGION_SFA = 3'h1,
        MMDEC_REGION_RAM = 3'h2,
        MMDEC_REGION_DFL = 3'h3,
        MMDEC_REGION_ROM = 3'h4
    } mmdec_region_t;

    typedef enum logic [2:0] {
        MMDEC_GRP_NONE = 3'h0,
        MMDEC_GRP_SERIAL = 3'h1,
        MMDEC_GRP_CONV = 3'h2,
        MMDEC_GRP_PORT = 3'h3,
        MMDEC_GRP_TIMER = 3'h4,
        MMDEC_GRP_BUSPROTO = 3'h5
    } mmdec_group_t;
endpackage

// ===== src/mmdec_reg_decode.sv
/*
 Peripheral register group decoder inside the special function area.
 Assumes a 20-bit address; all outputs are combinational.
*/
`include "mmdec_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module mmdec_reg_decode (
    input wire logic [19:0] addr,
    output logic reg_hit,
    output logic [7:0] reg_index,
    output logic [2:0] reg_group,
    output logic reg_high_byte
);
    // Offset from the first peripheral byte covered by the table.
    wire [19:0] rel = addr - `MMDEC_REG_BASE;
    wire in_window = (addr >= `MMDEC_REG_BASE) && (addr <= 20'h00132);
    wire [7:0] idx = rel[7:0];

    // Assigned register bytes, one flag per register group from 00A0h.
    wire serial = (addr >= 20'h000a0) && (addr <= 20'h000a6); // [R08]
    wire conv = (addr == 20'h000c0) || (addr == 20'h000c1) || (addr == 20'h000d4)
        || (addr == 20'h000d6) || (addr == 20'h000d7) || (addr == 20'h000d8)
        || (addr == 20'h000da) || (addr == 20'h000dc); // [R09]
    wire port_lo = (addr >= 20'h000e0) && (addr <= 20'h000eb) && (addr != 20'h000e4)
        && (addr != 20'h000e6); // [R10]
    wire port_hi = (addr >= 20'h000f5) && (addr <= 20'h000ff); // [R10]
    wire busproto = (addr == 20'h00106) || (addr == 20'h00107); // [R11]
    wire timer = ((addr >= 20'h00100) && (addr <= 20'h00104))
        || ((addr >= 20'h00108) && (addr <= 20'h0010e))
        || (addr == 20'h00118) || (addr == 20'h00119)
        || ((addr >= 20'h0011c) && (addr <= 20'h0011e))
        || ((addr >= 20'h00120) && (addr <= 20'h00132)); // [R11]
    wire port = port_lo || port_hi;

    // Gaps between assigned bytes hit nothing.
    assign reg_hit = in_window && (serial || conv || port || busproto || timer); // [R07]
    assign reg_index = reg_hit ? idx : 8'h00;
    assign reg_group = !reg_hit ? 3'h0 : serial ? 3'h1 : conv ? 3'h2 : port ? 3'h3
        : busproto ? 3'h5 : 3'h4;
    // Word registers: odd byte of the pair carries the high half.
    assign reg_high_byte = reg_hit && addr[0] && ((addr == 20'h000c1)
        || ((addr >= 20'h00126) && (addr <= 20'h0012f))); // [R12]
endmodule

`default_nettype wire

// ===== src/mmdec_top.sv
/*
 Memory map address decoder: steers each core address to one target region.
 Assumes the core holds the address stable for the cycle; selects are registered, one cycle after the address.
*/
`include "mmdec_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module mmdec_top (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [19:0] core_addr,
    input wire logic core_valid,
    output logic sel_special_function_area,
    output logic sel_ram,
    output logic sel_data_flash,
    output logic sel_program_rom,
    output logic sel_vector_table,
    output logic sel_reserved,
    output logic [2:0] region,
    output logic [2:0] reg_group,
    output logic [7:0] reg_index,
    output logic reg_high_byte,
    output logic [19:0] target_offset
);
    wire reg_hit;
    wire [7:0] reg_idx;
    wire [2:0] reg_grp;
    wire reg_hi;

    mmdec_reg_decode u_reg (
        .addr(core_addr),
        .reg_hit(reg_hit),
        .reg_index(reg_idx),
        .reg_group(reg_grp),
        .reg_high_byte(reg_hi)
    );

    // Region compares, all purely combinational on the address.
    wire hit_sfa = core_addr <= `MMDEC_SFA_HI; // [R06] [R14]
    wire hit_sfa_reg = hit_sfa && reg_hit; // [R07]
    wire hit_ram = (core_addr >= `MMDEC_RAM_LO)
        && (core_addr < (`MMDEC_RAM_LO + `MMDEC_RAM_SIZE)); // [R05]
    wire hit_dfl = (core_addr >= `MMDEC_DFL_LO) && (core_addr <= `MMDEC_DFL_HI); // [R04]
    wire hit_rom = (core_addr > (`MMDEC_ROM_TOP - `MMDEC_ROM_SIZE))
        && (core_addr <= `MMDEC_ROM_TOP); // [R02]
    wire hit_vec = (core_addr >= `MMDEC_VEC_LO) && (core_addr <= `MMDEC_ROM_TOP); // [R03]

    // Exactly one class per address; anything else is reserved.
    wire [2:0] next_region = !core_valid ? mmdec_pkg::MMDEC_REGION_NONE
        : hit_sfa_reg ? mmdec_pkg::MMDEC_REGION_SFA
        : hit_ram ? mmdec_pkg::MMDEC_REGION_RAM
        : hit_dfl ? mmdec_pkg::MMDEC_REGION_DFL
        : hit_rom ? mmdec_pkg::MMDEC_REGION_ROM
        : mmdec_pkg::MMDEC_REGION_NONE; // [R01] [R13]
    wire [19:0] next_offset = (next_region == mmdec_pkg::MMDEC_REGION_RAM)
        ? core_addr - `MMDEC_RAM_LO
        : (next_region == mmdec_pkg::MMDEC_REGION_DFL) ? core_addr - `MMDEC_DFL_LO
        : (next_region == mmdec_pkg::MMDEC_REGION_ROM)
        ? core_addr - (`MMDEC_ROM_TOP - `MMDEC_ROM_SIZE + 20'h00001)
        : (next_region == mmdec_pkg::MMDEC_REGION_SFA) ? core_addr : 20'h00000;
    wire is_sfa = next_region == mmdec_pkg::MMDEC_REGION_SFA;

    // Registered copies of the decode; the cycle after the address is presented.
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sel_special_function_area <= 1'b0;
            sel_ram <= 1'b0;
            sel_data_flash <= 1'b0;
            sel_program_rom <= 1'b0;
            sel_vector_table <= 1'b0;
            sel_reserved <= 1'b0;
            region <= 3'h0;
            reg_group <= 3'h0;
            reg_index <= 8'h00;
            reg_high_byte <= 1'b0;
            target_offset <= 20'h00000;
        end
        else
        begin
            sel_special_function_area <= is_sfa;
            sel_ram <= next_region == mmdec_pkg::MMDEC_REGION_RAM;
            sel_data_flash <= next_region == mmdec_pkg::MMDEC_REGION_DFL;
            sel_program_rom <= next_region == mmdec_pkg::MMDEC_REGION_ROM;
            sel_vector_table <= core_valid && hit_vec; // [R03]
            sel_reserved <= core_valid && (next_region == mmdec_pkg::MMDEC_REGION_NONE); // [R13]
            region <= next_region;
            reg_group <= is_sfa ? reg_grp : 3'h0; // [R08] [R09] [R10] [R11]
            reg_index <= is_sfa ? reg_idx : 8'h00;
            reg_high_byte <= is_sfa && reg_hi; // [R12]
            target_offset <= next_offset;
        end
    end
endmodule

`default_nettype wire

// ===== dv/mmdec_chk.sv
/* Assertions on decoder outputs against the access sampled one edge earlier.
 Bound into mmdec_top; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module mmdec_chk (input wire logic ref_clk, input wire logic arst_n, input wire logic core_valid,
    input wire logic [19:0] core_addr, input wire logic sel_special_function_area,
    input wire logic sel_ram, input wire logic sel_data_flash, input wire logic sel_program_rom,
    input wire logic sel_vector_table, input wire logic sel_reserved,
    input wire logic [2:0] reg_group, input wire logic reg_high_byte);
    logic [19:0] pa;
    logic pv;
    // Access the outputs answer; edges in reset clear it, as they clear the outputs.
    always_ff @(posedge ref_clk) {pv, pa} <= {arst_n && core_valid, core_addr};
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    property p_ram; sel_ram == (pv && pa inside {[20'h400:20'h7ff]}); endproperty
    a_ram: assert property (p_ram) else $error("ram select");
    property p_dfl; sel_data_flash == (pv && pa inside {[20'h2400:20'h2bff]}); endproperty
    a_dfl: assert property (p_dfl) else $error("flash select");
    property p_rom; sel_program_rom == (pv && pa inside {[20'hc000:20'hffff]}); endproperty
    a_rom: assert property (p_rom) else $error("rom select");
    property p_vec; sel_vector_table |-> sel_program_rom && pa >= 20'hffdc; endproperty
    a_vec: assert property (p_vec) else $error("vector select");
    property p_sfa; sel_special_function_area |-> pa <= 20'h2ff && reg_group != 3'h0; endproperty
    a_sfa: assert property (p_sfa) else $error("special select");
    property p_one; $countones({sel_special_function_area, sel_ram, sel_data_flash,
        sel_program_rom, sel_reserved}) == 32'(pv); endproperty
    a_one: assert property (p_one) else $error("select count");
    property p_ser; (reg_group == 3'h1) == (pv && pa inside {[20'ha0:20'ha6]}); endproperty
    a_ser: assert property (p_ser) else $error("serial group");
    property p_hb; reg_high_byte == (pv && pa[0] && pa inside {20'hc1, [20'h126:20'h12f]});
    endproperty
    a_hb: assert property (p_hb) else $error("high byte");
endmodule
`default_nettype wire

// ===== dv/mmdec_core_model.sv
/* Core model: presents each requested address one edge later.
 Assumes requests change just after a rising ref_clk edge. */
`timescale 1ns/1ps
`default_nettype none
module mmdec_core_model (input wire logic ref_clk, input wire logic arst_n,
    input wire logic [19:0] req_addr, input wire logic req_valid,
    output logic [19:0] core_addr, output logic core_valid);
    // Idle cycles show the inverted last address, so a stale one never looks valid.
    always_ff @(posedge ref_clk or negedge arst_n)
        core_valid <= arst_n && req_valid;
    always_ff @(posedge ref_clk or negedge arst_n)
        core_addr <= !arst_n ? 20'h0 : req_valid ? req_addr : ~core_addr;
endmodule
`default_nettype wire

// ===== dv/mmdec_tb_top.sv
/* Bench: random core traffic, about half near map edges, checked against a reference model.
 Assumes the decoder answers one edge after the core presents an address. */
`timescale 1ns/1ps
`default_nettype none
module mmdec_tb_top;
    logic ref_clk = 1'b0, arst_n = 1'b0, rv = 1'b0, pv = 1'b0, cv, s0, s1, s2, s3, s4, s5, hb;
    logic [19:0] ra = 20'h0, pa = 20'h0, ca, toff;
    logic [0:7][19:0] bt = {20'h80, 20'h280, 20'h380, 20'h780, 20'h2380, 20'h2b80, 20'hbf80, 20'hff80};
    logic [2:0] grp, rgn;
    logic [7:0] idx;
    logic [31:0] seed = 32'h15f30;
    int error_cnt = 0, tests_run = 0;
    mmdec_core_model u_core (.ref_clk, .arst_n, .req_addr(ra), .req_valid(rv), .core_addr(ca),
        .core_valid(cv));
    mmdec_top dut (.ref_clk, .arst_n, .core_addr(ca), .core_valid(cv), .region(rgn),
        .sel_special_function_area(s0), .sel_ram(s1), .sel_data_flash(s2), .sel_program_rom(s3),
        .sel_vector_table(s4), .sel_reserved(s5), .reg_group(grp), .reg_index(idx),
        .reg_high_byte(hb), .target_offset(toff));
    // Reference answer; a zero group marks a byte with no register.
    wire logic [2:0] g = !pv ? 3'h0 : pa inside {[20'ha0:20'ha6]} ? 3'h1 :
        pa inside {20'hc0, 20'hc1, 20'hd4, [20'hd6:20'hd8], 20'hda, 20'hdc} ? 3'h2 :
        pa inside {[20'he0:20'he3], 20'he5, [20'he7:20'heb], [20'hf5:20'hff]} ? 3'h3 :
        pa inside {20'h106, 20'h107} ? 3'h5 : pa inside {[20'h100:20'h104], [20'h108:20'h10e],
        20'h118, 20'h119, [20'h11c:20'h11e], [20'h120:20'h132]} ? 3'h4 : 3'h0;
    wire logic [2:0] m = {pv && pa inside {[20'h400:20'h7ff]},
        pv && pa inside {[20'h2400:20'h2bff]}, pv && pa inside {[20'hc000:20'hffff]}};
    wire logic [5:0] sel_exp = {g != 3'h0, m, m[0] && pa >= 20'hffdc, pv && g == 3'h0 && m == 3'h0};
    wire logic [11:0] reg_exp = {g, pv && pa[0] && pa inside {20'hc1, [20'h126:20'h12f]},
        g != 3'h0 ? 8'(pa - 20'ha0) : 8'h0};
    // Region code and offset inside the region, from the map bounds.
    wire logic [2:0] rgn_exp = g != 3'h0 ? 3'h1 : m[2] ? 3'h2 : m[1] ? 3'h3 : m[0] ? 3'h4 : 3'h0;
    wire logic [19:0] off_exp = g != 3'h0 ? pa : m[2] ? pa - 20'h400 : m[1] ? pa - 20'h2400
        : m[0] ? pa - 20'hc000 : 20'h0;
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        error_cnt += int'(got !== exp);
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Samples the access the design takes; answers are compared once settled.
    always @(posedge ref_clk) {pv, pa} <= {arst_n && cv, ca};
    always @(negedge ref_clk)
    begin
        chk("selects", sel_exp, {s0, s1, s2, s3, s4, s5});
        chk("register", reg_exp, {grp, hb, idx});
        chk("region", rgn_exp, rgn);
        chk("offset", off_exp, toff);
    end
    initial forever #10 ref_clk = ~ref_clk;
    // Biased random traffic: about half just around region and register edges.
    initial
    begin
        repeat (8) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (3000)
        begin
            @(posedge ref_clk);
            seed = seed ^ (seed << 13);
            seed = seed ^ (seed >> 17);
            seed = seed ^ (seed << 5);
            ra <= seed[24] ? seed[19:0] : bt[seed[2:0]] + {12'h0, seed[12:5]};
            rv <= seed[31:30] != 2'h0;
        end
        $display("test random access done");
        complete_run;
    end
    initial
    begin
        repeat (4000) @(posedge ref_clk);
        error_cnt++;
        complete_run;
    end
endmodule
bind mmdec_top mmdec_chk u_chk (.ref_clk, .arst_n, .core_valid, .core_addr, .sel_ram,
    .sel_special_function_area, .sel_data_flash, .sel_program_rom, .sel_vector_table,
    .sel_reserved, .reg_group, .reg_high_byte);
`default_nettype wire
